// >>> rtl/eau_defs.vh
// constants of the effective address unit
// assumes byte-wide opcode stream and 16-bit memory addresses
`ifndef EAU_DEFS_VH
`define EAU_DEFS_VH

// prefix bytes
`define EAU_PRE_SWAP_Y 8'h90
`define EAU_PRE_IND 8'h92
`define EAU_PRE_IND_Y 8'h91

// opcode high nibble groups
`define EAU_GRP_BITREL 4'h0
`define EAU_GRP_BIT 4'h1
`define EAU_GRP_REL 4'h2
`define EAU_GRP_RMW_DIR 4'h3
`define EAU_GRP_INH_A 4'h4
`define EAU_GRP_INH_X 4'h5
`define EAU_GRP_RMW_IDXS 4'h6
`define EAU_GRP_RMW_IDX0 4'h7
`define EAU_GRP_INH_M1 4'h8
`define EAU_GRP_INH_M2 4'h9
`define EAU_GRP_IMM 4'ha
`define EAU_GRP_DIR_S 4'hb
`define EAU_GRP_DIR_L 4'hc
`define EAU_GRP_IDX_L 4'hd
`define EAU_GRP_IDX_S 4'he
`define EAU_GRP_IDX_0 4'hf

// addressing mode codes
`define EAU_M_INH 5'h00
`define EAU_M_IMM 5'h01
`define EAU_M_DIR_S 5'h02
`define EAU_M_DIR_L 5'h03
`define EAU_M_IDX_0 5'h04
`define EAU_M_IDX_S 5'h05
`define EAU_M_IDX_L 5'h06
`define EAU_M_IND_S 5'h07
`define EAU_M_IND_L 5'h08
`define EAU_M_IIX_S 5'h09
`define EAU_M_IIX_L 5'h0a
`define EAU_M_REL 5'h0b
`define EAU_M_REL_IND 5'h0c
`define EAU_M_BIT 5'h0d
`define EAU_M_BIT_IND 5'h0e
`define EAU_M_BITREL 5'h0f
`define EAU_M_BITREL_IND 5'h10

// byte counts
`define EAU_CNT_NONE 2'd0
`define EAU_CNT_BYTE 2'd1
`define EAU_CNT_WORD 2'd2

// widths and reset values
`define EAU_PAGE0_HI 8'h00
`define EAU_ZERO16 16'h0000
`define EAU_ZERO8 8'h00
`define EAU_LEN_ONE 3'd1
`define EAU_LEN_ZERO 3'h0

`endif

// >>> rtl/eau_mode_decode.v
// mode decoder: prefix and opcode to addressing mode and byte counts
// assumes prefix code is zero when no prefix byte preceded the opcode
`timescale 1ns/100ps
`include "eau_defs.vh"

module eau_mode_decode (
	// instruction
	input wire [7:0] prefix,
	input wire [7:0] opcode,
	// decoded mode
	output reg [4:0] mode,
	output reg [1:0] opndCnt,
	output reg [1:0] ptrSize,
	output reg useIdx,
	output reg useY,
	output reg tailDisp,
	output reg isRel,
	output reg isImm
);

	wire preInd = (prefix == `EAU_PRE_IND);
	wire preIndY = (prefix == `EAU_PRE_IND_Y);

	always @*
	begin
		mode = `EAU_M_INH;
		opndCnt = `EAU_CNT_NONE;
		ptrSize = `EAU_CNT_NONE;
		useIdx = 1'b0;
		tailDisp = 1'b0;
		isRel = 1'b0;
		isImm = 1'b0;
		useY = (prefix == `EAU_PRE_SWAP_Y) | preIndY;
		// memory-to-memory groups have short forms only
		case (opcode[7:4])
			`EAU_GRP_BITREL:
			begin
				mode = preInd ? `EAU_M_BITREL_IND : `EAU_M_BITREL;
				opndCnt = `EAU_CNT_BYTE;
				ptrSize = preInd ? `EAU_CNT_BYTE : `EAU_CNT_NONE;
				tailDisp = 1'b1;
				isRel = 1'b1;
			end
			`EAU_GRP_BIT:
			begin
				mode = preInd ? `EAU_M_BIT_IND : `EAU_M_BIT;
				opndCnt = `EAU_CNT_BYTE;
				ptrSize = preInd ? `EAU_CNT_BYTE : `EAU_CNT_NONE;
			end
			`EAU_GRP_REL:
			begin
				mode = preInd ? `EAU_M_REL_IND : `EAU_M_REL;
				opndCnt = `EAU_CNT_BYTE;
				ptrSize = preInd ? `EAU_CNT_BYTE : `EAU_CNT_NONE;
				isRel = 1'b1;
			end
			`EAU_GRP_RMW_DIR, `EAU_GRP_DIR_S:
			begin
				mode = preInd ? `EAU_M_IND_S : `EAU_M_DIR_S;
				opndCnt = `EAU_CNT_BYTE;
				ptrSize = preInd ? `EAU_CNT_BYTE : `EAU_CNT_NONE;
			end
			`EAU_GRP_DIR_L:
			begin
				mode = preInd ? `EAU_M_IND_L : `EAU_M_DIR_L;
				opndCnt = preInd ? `EAU_CNT_BYTE : `EAU_CNT_WORD;
				ptrSize = preInd ? `EAU_CNT_WORD : `EAU_CNT_NONE;
			end
			`EAU_GRP_RMW_IDXS, `EAU_GRP_IDX_S:
			begin
				mode = (preInd | preIndY) ? `EAU_M_IIX_S : `EAU_M_IDX_S;
				opndCnt = `EAU_CNT_BYTE;
				ptrSize = (preInd | preIndY) ? `EAU_CNT_BYTE : `EAU_CNT_NONE;
				useIdx = 1'b1;
			end
			`EAU_GRP_IDX_L:
			begin
				mode = (preInd | preIndY) ? `EAU_M_IIX_L : `EAU_M_IDX_L;
				opndCnt = (preInd | preIndY) ? `EAU_CNT_BYTE : `EAU_CNT_WORD;
				ptrSize = (preInd | preIndY) ? `EAU_CNT_WORD : `EAU_CNT_NONE;
				useIdx = 1'b1;
			end
			`EAU_GRP_RMW_IDX0, `EAU_GRP_IDX_0:
			begin
				mode = `EAU_M_IDX_0;
				useIdx = 1'b1;
			end
			`EAU_GRP_IMM:
			begin
				mode = `EAU_M_IMM;
				opndCnt = `EAU_CNT_BYTE;
				isImm = 1'b1;
			end
			default:
			begin
				mode = `EAU_M_INH;
			end
		endcase
	end

endmodule

// >>> rtl/eau_addr_add.v
// 16-bit base plus 8-bit addend, unsigned or sign-extended
// assumes purely combinational use on one clock
`timescale 1ns/100ps

module eau_addr_add (
	// operands
	input wire [15:0] base,
	input wire [7:0] addend,
	input wire signExt,
	// result
	output wire [15:0] sum
);

	// wraps at 64 Kbyte, as the long forms expect
	wire [15:0] ext = {(signExt ? {8{addend[7]}} : 8'h00), addend};
	assign sum = base + ext;

endmodule

// >>> rtl/eau_core.v
// effective address unit: operand byte count and address forming
// assumes fetch stream and memory bus run on core_clk, no pins involved
//
// Overview of operation
// - short forms keep operand address in page zero unless indexed
// - long forms reach the whole 64 Kbyte space with extra bytes
// - memory-to-memory instructions exist only in short forms
// - inherent instructions are one byte, or two after a prefix, no operand bytes
// - immediate takes one operand byte as the value itself
// - short direct takes one address byte, 00 to FF
// - long direct takes two address bytes, 16-bit address
// - indexed address is unsigned sum of chosen index and offset
// - no-offset indexed uses index alone, no extra byte
// - short indexed adds byte offset to index, 00 to 1FE
// - long indexed adds index to two-byte offset
// - indirect reads a pointer at the address after opcode
// - short indirect reads a one-byte pointer, 00 to FF
// - long indirect forms read a 16-bit pointer
// - indirect-indexed adds index to pointer read
// - short indirect-indexed adds byte pointer to index, 00 to 1FE
// - relative adds signed byte to next-instruction address
// - swap prefix uses second index instead of first
// - indirect prefix turns direct and offset indexed into indirect forms; no-offset indexed stays as it is
// - indirect-second prefix uses second index in indirect-indexed
`timescale 1ns/100ps
`include "eau_defs.vh"

module eau_core (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// instruction byte stream
	input wire byteValid,
	input wire [7:0] byteData,
	input wire [15:0] bytePc,
	output reg byteReady_q,
	// index registers
	input wire [7:0] idxFirst,
	input wire [7:0] idxSecond,
	// pointer read port
	output reg memReq_q,
	output reg [15:0] memAddr_q,
	input wire memAck,
	input wire [7:0] memRdata,
	// result
	output reg eaValid_q,
	output reg [15:0] eaAddr_q,
	output reg hasEa_q,
	output reg [7:0] immValue_q,
	output reg isImm_q,
	output reg [15:0] branchTarget_q,
	output reg isRel_q,
	output reg [4:0] mode_q,
	output reg [7:0] opcode_q,
	output reg [2:0] instrLen_q,
	output reg [15:0] nextPc_q
);

	localparam [5:0] S_OPC = 6'b000001;
	localparam [5:0] S_DEC = 6'b000010;
	localparam [5:0] S_OPND = 6'b000100;
	localparam [5:0] S_PTR = 6'b001000;
	localparam [5:0] S_TAIL = 6'b010000;
	localparam [5:0] S_CALC = 6'b100000;

	reg [5:0] state_q;
	reg [7:0] prefix_q;
	reg [7:0] opc_q;
	reg [15:0] opnd_q;
	reg [15:0] ptr_q;
	reg [7:0] tail_q;
	reg [1:0] cnt_q;
	reg [1:0] ptrIdx_q;
	reg [2:0] len_q;
	reg [15:0] startPc_q;

	wire [4:0] decMode;
	wire [1:0] decOpndCnt;
	wire [1:0] decPtrSize;
	wire decUseIdx;
	wire decUseY;
	wire decTail;
	wire decRel;
	wire decImm;

	eau_mode_decode uDecode (
		.prefix(prefix_q),
		.opcode(opc_q),
		.mode(decMode),
		.opndCnt(decOpndCnt),
		.ptrSize(decPtrSize),
		.useIdx(decUseIdx),
		.useY(decUseY),
		.tailDisp(decTail),
		.isRel(decRel),
		.isImm(decImm)
	);

	wire take = byteValid & byteReady_q;
	wire isPrefix = (byteData == `EAU_PRE_SWAP_Y) | (byteData == `EAU_PRE_IND) |
		(byteData == `EAU_PRE_IND_Y);

	// address base: pointer when indirect, else operand bytes
	reg [15:0] eaBase;
	always @*
	begin
		if (decPtrSize != `EAU_CNT_NONE)
			eaBase = ptr_q;
		else
			eaBase = opnd_q;
	end

	reg [7:0] idxSel;
	always @*
	begin
		if (decUseY)
			idxSel = idxSecond;
		else
			idxSel = idxFirst;
	end

	wire [15:0] idxSum;
	eau_addr_add uIdxAdd (
		.base(eaBase),
		.addend(idxSel),
		.signExt(1'b0),
		.sum(idxSum)
	);

	// short bases are zero-extended, so page zero unless indexed
	wire [15:0] eaNext = decUseIdx ? idxSum : eaBase;

	wire [15:0] pcAfter = startPc_q + {13'h0000, len_q};
	// displacement: tail byte, else pointer read, else operand byte
	reg [7:0] relDisp;
	always @*
	begin
		if (decTail)
			relDisp = tail_q;
		else if (decPtrSize != `EAU_CNT_NONE)
			relDisp = ptr_q[7:0];
		else
			relDisp = opnd_q[7:0];
	end
	wire [15:0] relSum;
	eau_addr_add uRelAdd (
		.base(pcAfter),
		.addend(relDisp),
		.signExt(1'b1),
		.sum(relSum)
	);

	// pointer address lives in page zero; word pointer steps one byte on
	wire [15:0] ptrBase = {`EAU_PAGE0_HI, opnd_q[7:0]};
	wire [15:0] ptrAddr = ptrBase + {14'h0000, ptrIdx_q};
	wire ptrLast = ((ptrIdx_q + 2'd1) == decPtrSize);

	// only modes that touch a data operand report an address
	reg hasEa_d;
	always @*
	begin
		case (decMode)
			`EAU_M_INH, `EAU_M_IMM, `EAU_M_REL, `EAU_M_REL_IND:
			begin
				hasEa_d = 1'b0;
			end
			default:
			begin
				hasEa_d = 1'b1;
			end
		endcase
	end

	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			state_q <= S_OPC;
			prefix_q <= `EAU_ZERO8;
			opc_q <= `EAU_ZERO8;
			opnd_q <= `EAU_ZERO16;
			ptr_q <= `EAU_ZERO16;
			tail_q <= `EAU_ZERO8;
			cnt_q <= `EAU_CNT_NONE;
			ptrIdx_q <= `EAU_CNT_NONE;
			len_q <= `EAU_LEN_ZERO;
			startPc_q <= `EAU_ZERO16;
			byteReady_q <= 1'b0;
			memReq_q <= 1'b0;
			memAddr_q <= `EAU_ZERO16;
			eaValid_q <= 1'b0;
		end
		else
		begin
			eaValid_q <= 1'b0;
			case (state_q)
				S_OPC:
				begin
					byteReady_q <= 1'b1;
					if (take)
					begin
						if (len_q == `EAU_LEN_ZERO)
							startPc_q <= bytePc;
						len_q <= len_q + 3'd1;
						// only one prefix per instruction; a second is an opcode
						if (isPrefix && prefix_q == `EAU_ZERO8)
							prefix_q <= byteData;
						else
						begin
							opc_q <= byteData;
							byteReady_q <= 1'b0;
							state_q <= S_DEC;
						end
					end
				end
				S_DEC:
				begin
					cnt_q <= decOpndCnt;
					ptrIdx_q <= `EAU_CNT_NONE;
					if (decOpndCnt != `EAU_CNT_NONE)
					begin
						byteReady_q <= 1'b1;
						state_q <= S_OPND;
					end
					else
						state_q <= S_CALC;
				end
				S_OPND:
				begin
					if (take)
					begin
						// first byte ends up high, second low
						opnd_q <= {opnd_q[7:0], byteData};
						len_q <= len_q + 3'd1;
						cnt_q <= cnt_q - 2'd1;
						if (cnt_q == `EAU_CNT_BYTE)
						begin
							byteReady_q <= 1'b0;
							if (decPtrSize != `EAU_CNT_NONE)
								state_q <= S_PTR;
							else if (decTail)
							begin
								byteReady_q <= 1'b1;
								state_q <= S_TAIL;
							end
							else
								state_q <= S_CALC;
						end
					end
				end
				S_PTR:
				begin
					if (!memReq_q)
					begin
						memReq_q <= 1'b1;
						memAddr_q <= ptrAddr;
					end
					else if (memAck)
					begin
						memReq_q <= 1'b0;
						ptr_q <= {ptr_q[7:0], memRdata};
						ptrIdx_q <= ptrIdx_q + 2'd1;
						if (ptrLast)
						begin
							if (decTail)
							begin
								byteReady_q <= 1'b1;
								state_q <= S_TAIL;
							end
							else
								state_q <= S_CALC;
						end
					end
				end
				S_TAIL:
				begin
					if (take)
					begin
						tail_q <= byteData;
						len_q <= len_q + 3'd1;
						byteReady_q <= 1'b0;
						state_q <= S_CALC;
					end
				end
				S_CALC:
				begin
					// results load in the block below
					eaValid_q <= 1'b1;
					// clear per-instruction state so short values zero-extend
					prefix_q <= `EAU_ZERO8;
					opnd_q <= `EAU_ZERO16;
					ptr_q <= `EAU_ZERO16;
					tail_q <= `EAU_ZERO8;
					len_q <= `EAU_LEN_ZERO;
					byteReady_q <= 1'b1;
					state_q <= S_OPC;
				end
				default:
				begin
					state_q <= S_OPC;
					byteReady_q <= 1'b0;
					memReq_q <= 1'b0;
				end
			endcase
		end
	end

	// results hold until the next pulse, so a slow user may sample late
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			eaAddr_q <= `EAU_ZERO16;
			hasEa_q <= 1'b0;
			immValue_q <= `EAU_ZERO8;
			isImm_q <= 1'b0;
			branchTarget_q <= `EAU_ZERO16;
			isRel_q <= 1'b0;
			mode_q <= `EAU_M_INH;
			opcode_q <= `EAU_ZERO8;
			instrLen_q <= `EAU_LEN_ZERO;
			nextPc_q <= `EAU_ZERO16;
		end
		else if (state_q == S_CALC)
		begin
			eaAddr_q <= eaNext;
			hasEa_q <= hasEa_d;
			immValue_q <= opnd_q[7:0];
			isImm_q <= decImm;
			branchTarget_q <= relSum;
			isRel_q <= decRel;
			mode_q <= decMode;
			opcode_q <= opc_q;
			instrLen_q <= len_q;
			nextPc_q <= pcAfter;
		end
	end

endmodule

// >>> dv/eau_core_chk.sv
// checker for the effective address unit
// assumes bound to eau_core, sees only its ports
`timescale 1ns/100ps
`include "eau_defs.vh"
module eau_core_chk (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// watched ports
	input wire byteReady_q,
	input wire memReq_q,
	input wire [15:0] memAddr_q,
	input wire memAck,
	input wire eaValid_q,
	input wire [15:0] eaAddr_q,
	input wire hasEa_q,
	input wire isImm_q,
	input wire [4:0] mode_q,
	input wire [2:0] instrLen_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_dir_short_page: assert property (
		eaValid_q && mode_q == `EAU_M_DIR_S |-> eaAddr_q[15:8] == 8'h00 && hasEa_q)
		else $error("short direct left page zero");
	a_dir_long_len: assert property (
		eaValid_q && mode_q == `EAU_M_DIR_L |-> instrLen_q == 3'd3 || instrLen_q == 3'd4)
		else $error("long direct length wrong");
	a_idx0_page: assert property (
		eaValid_q && mode_q == `EAU_M_IDX_0 |-> eaAddr_q[15:8] == 8'h00)
		else $error("no-offset indexed out of range");
	a_idx_short_range: assert property (
		eaValid_q && mode_q == `EAU_M_IDX_S |-> eaAddr_q <= 16'h01fe)
		else $error("short indexed above 1fe");
	a_ind_short_page: assert property (
		eaValid_q && mode_q == `EAU_M_IND_S |-> eaAddr_q[15:8] == 8'h00)
		else $error("short indirect left page zero");
	a_iix_short_range: assert property (
		eaValid_q && mode_q == `EAU_M_IIX_S |-> eaAddr_q <= 16'h01fe)
		else $error("short indirect-indexed above 1fe");
	a_inh_len: assert property (
		eaValid_q && mode_q == `EAU_M_INH |-> !hasEa_q && instrLen_q <= 3'd2)
		else $error("inherent carries operand bytes");
	a_imm_mode: assert property (
		eaValid_q && isImm_q |-> mode_q == `EAU_M_IMM && !hasEa_q)
		else $error("immediate flagged with address");
	a_req_hold: assert property (
		memReq_q && !memAck |=> memReq_q && $stable(memAddr_q))
		else $error("pointer read dropped early");
	a_req_drop: assert property (
		memReq_q && memAck |=> !memReq_q)
		else $error("pointer read kept after ack");
	a_ptr_noready: assert property (
		memReq_q |-> !byteReady_q)
		else $error("bytes taken during pointer read");
endmodule
bind eau_core eau_core_chk i_eau_core_chk (.core_clk(core_clk), .nrst(nrst),
	.byteReady_q(byteReady_q), .memReq_q(memReq_q), .memAddr_q(memAddr_q), .memAck(memAck),
	.eaValid_q(eaValid_q), .eaAddr_q(eaAddr_q), .hasEa_q(hasEa_q), .isImm_q(isImm_q),
	.mode_q(mode_q), .instrLen_q(instrLen_q));

// >>> dv/eau_mem_model.sv
// memory model answering pointer reads
// assumes one request at a time, held until acknowledged
`timescale 1ns/100ps
module eau_mem_model (
	// clock
	input wire core_clk,
	// read port
	input wire memReq,
	input wire [15:0] memAddr,
	input wire [3:0] lat,
	output reg memAck,
	output reg [7:0] memRdata
);
	reg [3:0] waitCnt_q;
	initial
	begin
		memAck = 1'b0;
		memRdata = 8'h00;
		waitCnt_q = 4'h0;
	end
	// data toggles outside ack so a stale byte never looks valid
	always @(posedge core_clk)
	begin
		memAck <= 1'b0;
		memRdata <= ~memRdata;
		if (memReq && !memAck && waitCnt_q >= lat)
		begin
			memAck <= 1'b1;
			memRdata <= memAddr[7:0] ^ 8'ha5;
			waitCnt_q <= 4'h0;
		end
		else if (memReq && !memAck)
			waitCnt_q <= waitCnt_q + 4'h1;
	end
endmodule

// >>> dv/tb.sv
// testbench for the effective address unit
// assumes memory bytes are address low byte xor a5
`timescale 1ns/100ps
`include "eau_defs.vh"
module tb;
	reg core_clk, nrst, byteValid;
	reg [7:0] byteData, idxFirst, idxSecond;
	reg [15:0] bytePc;
	reg [3:0] lat;
	integer errors, checked, cyc;
	wire byteReady_q, memReq_q, memAck, eaValid_q, hasEa_q, isImm_q, isRel_q;
	wire [15:0] memAddr_q, eaAddr_q, branchTarget_q, nextPc_q;
	wire [7:0] memRdata, immValue_q, opcode_q;
	wire [4:0] mode_q;
	wire [2:0] instrLen_q;
	eau_core i_eau_core (.core_clk(core_clk), .nrst(nrst), .byteValid(byteValid),
		.byteData(byteData), .bytePc(bytePc), .byteReady_q(byteReady_q), .idxFirst(idxFirst),
		.idxSecond(idxSecond), .memReq_q(memReq_q), .memAddr_q(memAddr_q), .memAck(memAck),
		.memRdata(memRdata), .eaValid_q(eaValid_q), .eaAddr_q(eaAddr_q), .hasEa_q(hasEa_q),
		.immValue_q(immValue_q), .isImm_q(isImm_q), .branchTarget_q(branchTarget_q),
		.isRel_q(isRel_q), .mode_q(mode_q), .opcode_q(opcode_q), .instrLen_q(instrLen_q),
		.nextPc_q(nextPc_q));
	eau_mem_model i_eau_mem_model (.core_clk(core_clk), .memReq(memReq_q),
		.memAddr(memAddr_q), .lat(lat), .memAck(memAck), .memRdata(memRdata));
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task check(input [15:0] s, input [15:0] e);
	begin
		checked = checked + 1;
		if (s !== e)
		begin
			errors = errors + 1;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	end
	endtask
	// bytes held until taken, then wait for the result pulse
	task run(input [15:0] pc, input [31:0] b, input integer n);
		integer i, w;
	begin
		bytePc = pc;
		byteValid = 1'b1;
		for (i = 0; i < n; i = i + 1)
		begin
			byteData = b[31-8*i -: 8];
			w = 0;
			@(negedge core_clk);
			while (byteReady_q !== 1'b1 && w < 40)
			begin
				@(negedge core_clk);
				w = w + 1;
			end
			@(posedge core_clk);
			#1;
		end
		byteValid = 1'b0;
		w = 0;
		while (eaValid_q !== 1'b1 && w < 60)
		begin
			@(posedge core_clk);
			#1;
			w = w + 1;
		end
		check(w < 60, 1'b1);
	end
	endtask
	task res(input [15:0] ea, input [2:0] len);
	begin
		check(eaAddr_q, ea);
		check(instrLen_q, len);
	end
	endtask
	task t_basic;
	begin
		run(16'h0100, 32'h9d000000, 1);
		check({hasEa_q, instrLen_q}, 4'h1);
		check(nextPc_q, 16'h0101);
		check(opcode_q, 16'h009d);
		run(16'h0101, 32'ha6550000, 2);
		check({isImm_q, immValue_q}, 9'h155);
		run(16'h0103, 32'hb6800000, 2);
		res(16'h0080, 3'd2);
		run(16'h0105, 32'hc6123400, 3);
		res(16'h1234, 3'd3);
		run(16'h0108, 32'h3c800000, 2);
		res(16'h0080, 3'd2);
		$display("t_basic done");
	end
	endtask
	task t_idx;
	begin
		run(16'h0200, 32'hf6000000, 1);
		res(16'h00ff, 3'd1);
		run(16'h0201, 32'he6ff0000, 2);
		res(16'h01fe, 3'd2);
		run(16'h0203, 32'hd6120000, 3);
		res(16'h12ff, 3'd3);
		run(16'h0206, 32'h90e6ff00, 3);
		res(16'h013f, 3'd3);
		run(16'h0209, 32'h76000000, 1);
		res(16'h00ff, 3'd1);
		$display("t_idx done");
	end
	endtask
	task t_ind;
	begin
		run(16'h0300, 32'h92b61000, 3);
		res(16'h00b5, 3'd3);
		lat = 4'h5;
		run(16'h0303, 32'h92c62000, 3);
		res(16'h8584, 3'd3);
		check(memAddr_q, 16'h0021);
		check(mode_q, `EAU_M_IND_L);
		run(16'h0306, 32'h92e63000, 3);
		res(16'h0194, 3'd3);
		lat = 4'h0;
		run(16'h0309, 32'h91e63000, 3);
		res(16'h00d5, 3'd3);
		run(16'h030c, 32'h92d64000, 3);
		res(16'he6e3, 3'd3);
		run(16'h0310, 32'h92203000, 3);
		check(branchTarget_q, 16'h02a8);
		$display("t_ind done");
	end
	endtask
	task t_rel;
	begin
		run(16'h0400, 32'h20800000, 2);
		check({isRel_q, nextPc_q}, 17'h10402);
		check(branchTarget_q, 16'h0382);
		run(16'h0402, 32'h207f0000, 2);
		check(branchTarget_q, 16'h0483);
		$display("t_rel done");
	end
	endtask
	task t_bit;
	begin
		run(16'h0500, 32'h1e100000, 2);
		res(16'h0010, 3'd2);
		check({hasEa_q, mode_q}, {1'b1, `EAU_M_BIT});
		run(16'h0502, 32'h0e100500, 3);
		res(16'h0010, 3'd3);
		check(branchTarget_q, 16'h050a);
		run(16'h0505, 32'h921e1000, 3);
		res(16'h00b5, 3'd3);
		check(mode_q, `EAU_M_BIT_IND);
		lat = 4'h3;
		run(16'h0508, 32'h920e10fb, 4);
		res(16'h00b5, 3'd4);
		check({isRel_q, branchTarget_q}, 17'h10507);
		lat = 4'h0;
		$display("t_bit done");
	end
	endtask
	task final_report;
	begin
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	// a hang counts as a mismatch
	always @(posedge core_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 4000)
		begin
			errors = errors + 1;
			final_report;
		end
	end
	initial
	begin
		nrst = 1'b0;
		byteValid = 1'b0;
		byteData = 8'h00;
		bytePc = 16'h0000;
		idxFirst = 8'hff;
		idxSecond = 8'h40;
		lat = 4'h0;
		errors = 0;
		checked = 0;
		cyc = 0;
		repeat (16) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		t_basic;
		t_idx;
		t_ind;
		t_rel;
		t_bit;
		final_report;
	end
endmodule
